// ===== core/vcmc_pkg.sv
// Constants, types and helpers of the video colour matrix control block
// Contract
// - Three level registers colour the HD pattern
// - Automatic matrix follows input mode field
// - No RGB-to-YPrPb, no SD RGB input
// - Two select bits choose the conversion
// - Override resets off; coefficients need it
// - Override acts in progressive/HD only
// - Default coefficients give HDTV colour space
// - Matrix bypassed while test pattern runs
// - Coefficients split over high and low registers
// - RGB output uses three matrix sums
// - YPrPb output scales each component
// - Matrix registers load documented power-up values
// - SD scale factor is value over 512
// - SD scale high bytes, shared low register
// - SD scalers affect every interlaced output
// - Hue steps 0.17578125 degrees around 0x80
// - Hue shift reaches composite and chroma only
// - Brightness adds signed 7-bit setup to SD luma
// - Setup span depends on standard and pedestal; here a fixed seven-bit -64 to +63 in every mode
// - One bit switches the progressive/HD sinc filter
package vcmc_pkg;
	// Serial port device address; value is arbitrary
	localparam logic [6:0] VCMC_DEV_ADDR = 7'h2a;
	// Register offsets
	localparam logic [6:0] A_IN_MODE  = 7'h01;
	localparam logic [6:0] A_OUT_CTRL = 7'h02;
	localparam logic [6:0] A_GY_LO    = 7'h03;
	localparam logic [6:0] A_BR_LO    = 7'h04;
	localparam logic [6:0] A_GY_HI    = 7'h05;
	localparam logic [6:0] A_GV_HI    = 7'h06;
	localparam logic [6:0] A_GU_HI    = 7'h07;
	localparam logic [6:0] A_BU_HI    = 7'h08;
	localparam logic [6:0] A_RV_HI    = 7'h09;
	localparam logic [6:0] A_FILT     = 7'h13;
	localparam logic [6:0] A_IN_SPACE = 7'h15;
	localparam logic [6:0] A_PAT_Y    = 7'h16;
	localparam logic [6:0] A_PAT_CR   = 7'h17;
	localparam logic [6:0] A_PAT_CB   = 7'h18;
	localparam logic [6:0] A_SD_LSB   = 7'h5c;
	localparam logic [6:0] A_SD_Y     = 7'h5d;
	localparam logic [6:0] A_SD_CB    = 7'h5e;
	localparam logic [6:0] A_SD_CR    = 7'h5f;
	localparam logic [6:0] A_HUE      = 7'h60;
	localparam logic [6:0] A_SETUP    = 7'h61;
	// Field positions
	localparam int MODE_LSB = 4;
	localparam int OUT_SEL_BIT = 5;
	localparam int MANUAL_BIT = 3;
	localparam int SINC_BIT = 3;
	localparam int IN_SEL_BIT = 1;
	// Input mode codes and midpoints
	localparam logic [2:0] MODE_SD = 3'h0;
	localparam logic [2:0] MODE_PS = 3'h1;
	localparam logic [7:0] MID8 = 8'h80;
	localparam logic signed [21:0] MID_OUT = 22'sh20000;
	localparam logic signed [21:0] ROUND8 = 22'sh80;
	localparam logic signed [19:0] ROUND9 = 20'sh100;
	// Coefficient set: luma, pb-green, pr-green, pb-blue, pr-red
	typedef struct packed {
		logic [9:0] gy;
		logic [9:0] gu;
		logic [9:0] gv;
		logic [9:0] bu;
		logic [9:0] rv;
	} vcmc_coef_type;
	localparam vcmc_coef_type COEF_HD = '{10'h13b, 10'h093, 10'h03b, 10'h248, 10'h1f0};
	localparam vcmc_coef_type COEF_SD = '{10'h13b, 10'h06c, 10'h0e1, 10'h22f, 10'h1ba};
	// Pixel carriers
	typedef struct packed {
		logic       valid;
		logic [7:0] y;
		logic [7:0] cb;
		logic [7:0] cr;
	} vcmc_pix_in_type;
	typedef struct packed {
		logic       valid;
		logic [9:0] ch0;
		logic [9:0] ch1;
		logic [9:0] ch2;
	} vcmc_pix_out_type;
	// Power-up value of each register
	function automatic logic [7:0] vcmc_rst_val(input int a);
		case (a)
			32'h02: return 8'h20;
			32'h03: return 8'h03;
			32'h04: return 8'hf0;
			32'h05: return 8'h4e;
			32'h06: return 8'h0e;
			32'h07: return 8'h24;
			32'h08: return 8'h92;
			32'h09: return 8'h7c;
			32'h13: return 8'h08;
			32'h16: return 8'h10;
			32'h17: return 8'h80;
			32'h18: return 8'h80;
			32'h5d: return 8'h80;
			32'h5e: return 8'h80;
			32'h5f: return 8'h80;
			32'h60: return 8'h80;
			default: return 8'h00;
		endcase
	endfunction
	// Offsets that hold storage
	function automatic logic vcmc_mapped(input int a);
		return (a >= 1 && a <= 9) || a == 32'h13 || (a >= 32'h15 && a <= 32'h18) ||
			(a >= 32'h5c && a <= 32'h61);
	endfunction
endpackage

// ===== core/vcmc_top.sv
// Colour matrix, SD scaler and setup datapath with its serial register port
`timescale 1ns/1ps
module vcmc_top
	import vcmc_pkg::*;
(
	input  wire logic              clk_in,
	input  wire logic              rst_n_in,
	input  wire logic              scl_in,
	input  wire logic              sda_in,
	output logic                   sda_out,
	output logic                   sda_oe_out,
	input  wire vcmc_pix_in_type   pix_in,
	input  wire logic              pattern_en_in,
	output vcmc_pix_out_type       pix_out,
	output logic [7:0]             hue_step_out,
	output logic                   sinc_en_out
);

	// Serial transfer phases
	typedef enum logic [2:0] {
		S_IDLE,
		S_DEV,
		S_SUB,
		S_WR,
		S_RD
	} vcmc_ser_type;

	// Pin synchronisers; stage one feeds stage two only
	// The pins come from the far side of the bus with no clock relation,
	// so nothing but the second stage may look at a first-stage flop.
	// Both lines idle high, so the reset value matches the pulled-up bus
	// and no false start or clock edge follows reset.
	logic scl_s1_q;
	logic scl_s2_q;
	logic scl_s3_q;
	logic sda_s1_q;
	logic sda_s2_q;
	logic sda_s3_q;

	// Two flops, then one more for edge history
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			scl_s1_q <= 1'b1;
			scl_s2_q <= 1'b1;
			scl_s3_q <= 1'b1;
			sda_s1_q <= 1'b1;
			sda_s2_q <= 1'b1;
			sda_s3_q <= 1'b1;
		end else begin
			scl_s1_q <= scl_in;
			scl_s2_q <= scl_s1_q;
			scl_s3_q <= scl_s2_q;
			sda_s1_q <= sda_in;
			sda_s2_q <= sda_s1_q;
			sda_s3_q <= sda_s2_q;
		end
	end

	// Bus conditions
	// Edges compare stage two with the history flop, so each condition
	// is seen for exactly one cycle. A start or stop needs the clock to
	// have been high for two samples, which keeps a data change that
	// races the clock fall from looking like a start.
	wire scl_rise = scl_s2_q & ~scl_s3_q;
	wire scl_fall = ~scl_s2_q & scl_s3_q;
	wire bus_start = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
	wire bus_stop = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;

	// Serial engine state
	// All of it lives in the one clock domain; the pins only enter
	// through the synchronisers above, and the write strobe reaches
	// the register array one cycle after the byte is complete.
	vcmc_ser_type st_q;            // Transfer phase
	logic [3:0]   bit_cnt_q;       // Bits seen in this byte
	logic         ack_q;           // Inside the ninth clock
	logic [7:0]   shift_q;         // Received byte
	logic [7:0]   tx_q;            // Byte being sent
	logic [6:0]   sub_q;           // Auto-incrementing subaddress
	logic         rd_nack_q;       // Master refused more data
	logic         oe_q;            // Pulling the data line low
	logic         wr_en_q;         // One-cycle write strobe
	logic [6:0]   wr_addr_q;       // Write target
	logic [7:0]   wr_data_q;       // Write value

	// Register storage, indexed by subaddress
	// Reads are a plain mux on the subaddress; the array is small enough
	// that a flop per bit costs less than a separate memory and its port.
	logic [7:0] reg_q [0:127];
	wire [7:0] rd_data = reg_q[sub_q];
	wire addr_hit = (shift_q[7:1] == VCMC_DEV_ADDR);

	// Byte engine: sample on rising clock, drive on falling clock
	// The engine follows the master's clock through its synchronised edges.
	// Bits are taken when the clock is seen to rise, and the data line is
	// only changed after the clock has been seen to fall, so the line never
	// moves while the master's clock is high. The ninth clock of each byte
	// is the acknowledge slot; ack_q marks it.
	// Limitation: the master must hold each clock phase for at least four
	// cycles of clk_in, or an edge is lost in the synchronisers.
	// A foreign address parks the engine in idle until the next start.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_q <= S_IDLE;
			bit_cnt_q <= 4'h0;
			ack_q <= 1'b0;
			shift_q <= 8'h00;
			tx_q <= 8'h00;
			sub_q <= 7'h00;
			rd_nack_q <= 1'b0;
			oe_q <= 1'b0;
			wr_en_q <= 1'b0;
			wr_addr_q <= 7'h00;
			wr_data_q <= 8'h00;
		end else begin
			wr_en_q <= 1'b0;
			if (bus_start) begin
				// A repeated start restarts addressing
				st_q <= S_DEV;
				bit_cnt_q <= 4'h0;
				ack_q <= 1'b0;
				oe_q <= 1'b0;
				rd_nack_q <= 1'b0;
			end else if (bus_stop) begin
				st_q <= S_IDLE;
				ack_q <= 1'b0;
				oe_q <= 1'b0;
			end else if (st_q == S_IDLE) begin
				oe_q <= 1'b0;
			end else if (scl_rise) begin
				if (ack_q) begin
					// Master's answer to a read byte
					if (st_q == S_RD) begin
						rd_nack_q <= sda_s2_q;
					end
				end else begin
					shift_q <= {shift_q[6:0], sda_s2_q};
					bit_cnt_q <= bit_cnt_q + 4'h1;
				end
			end else if (scl_fall) begin
				if (ack_q) begin
					// Leave the ninth clock
					ack_q <= 1'b0;
					bit_cnt_q <= 4'h0;
					oe_q <= 1'b0;
					if (st_q == S_RD && !rd_nack_q) begin
						tx_q <= {rd_data[6:0], 1'b0};
						oe_q <= ~rd_data[7];
					end
				end else if (bit_cnt_q == 4'h8) begin
					ack_q <= 1'b1;
					case (st_q)
						S_DEV: begin
							// Only our own address is acknowledged
							if (addr_hit) begin
								oe_q <= 1'b1;
								st_q <= shift_q[0] ? S_RD : S_SUB;
							end else begin
								st_q <= S_IDLE;
							end
						end
						S_SUB: begin
							sub_q <= shift_q[6:0];
							oe_q <= 1'b1;
							st_q <= S_WR;
						end
						S_WR: begin
							wr_en_q <= 1'b1;
							wr_addr_q <= sub_q;
							wr_data_q <= shift_q;
							sub_q <= sub_q + 7'h1;
							oe_q <= 1'b1;
						end
						default: begin
							// Release the line for the master's answer
							oe_q <= 1'b0;
							sub_q <= sub_q + 7'h1;
						end
					endcase
				end else if (st_q == S_RD) begin
					oe_q <= ~tx_q[7] & ~rd_nack_q;
					tx_q <= {tx_q[6:0], 1'b0};
				end
			end
		end
	end

	// Open-drain data line; only ever pulled low
	// A one is left to the pull-up, so two drivers can never fight
	// on the line.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sda_out <= 1'b0;
			sda_oe_out <= 1'b0;
		end else begin
			sda_out <= 1'b0;
			sda_oe_out <= oe_q;
		end
	end

	// One flop group per subaddress; unmapped ones stay zero
	// Reset loads the power-up table. Writes to unmapped offsets are
	// acknowledged but land nowhere, so they read back zero.
	// The matrix words reset to values that decode to the HDTV set.
	for (genvar i = 0; i < 128; i++) begin : g_reg
		localparam logic [7:0] RST = vcmc_rst_val(i);
		localparam logic MAPPED = vcmc_mapped(i);
		wire hit = wr_en_q && (wr_addr_q == 7'(i)) && MAPPED;
		always_ff @(posedge clk_in or negedge rst_n_in) begin
			if (!rst_n_in) begin
				reg_q[i] <= RST;
			end else if (hit) begin
				reg_q[i] <= wr_data_q;
			end
		end
	end

	// Mode decoding
	// Input mode 0 is SD, 1 is progressive, anything else is HD.
	// All decodes are plain wires off the register array.
	wire [2:0] in_mode = reg_q[A_IN_MODE][MODE_LSB+2:MODE_LSB];
	wire is_sd = (in_mode == MODE_SD);
	wire is_ps = (in_mode == MODE_PS);
	// SD never takes RGB input; RGB in forces RGB out
	wire rgb_in = reg_q[A_IN_SPACE][IN_SEL_BIT] & ~is_sd;
	wire out_rgb = ~reg_q[A_OUT_CTRL][OUT_SEL_BIT] | rgb_in;
	// Override only counts outside SD
	wire manual = reg_q[A_OUT_CTRL][MANUAL_BIT] & ~is_sd;
	// The HD test pattern replaces the matrix path
	wire pat_on = pattern_en_in & ~is_sd;

	// Manual coefficients from high byte and low pair
	// Each coefficient is ten bits with eight fraction bits: the upper
	// eight sit in their own register, the lower two of luma in A_GY_LO, the rest in a shared one.
	// The shared register packs green-Pb, green-Pr, blue and red pairs.
	vcmc_coef_type man_coef;
	assign man_coef.gy = {reg_q[A_GY_HI], reg_q[A_GY_LO][1:0]};
	assign man_coef.gu = {reg_q[A_GU_HI], reg_q[A_BR_LO][7:6]};
	assign man_coef.gv = {reg_q[A_GV_HI], reg_q[A_BR_LO][5:4]};
	assign man_coef.bu = {reg_q[A_BU_HI], reg_q[A_BR_LO][3:2]};
	assign man_coef.rv = {reg_q[A_RV_HI], reg_q[A_BR_LO][1:0]};

	// Automatic set follows the input standard
	// Progressive input uses the SD colour space; only HD takes the
	// default set. The override replaces the whole set at once.
	wire vcmc_coef_type auto_coef = (is_sd || is_ps) ? COEF_SD : COEF_HD;
	wire vcmc_coef_type coef = manual ? man_coef : auto_coef;

	// SD scale factors: high byte plus shared low pairs
	// A factor of 512 is unity gain; software keeps luma at or below
	// 768 and the colour factors at or below 1023.
	wire [9:0] sc_y = {reg_q[A_SD_Y], reg_q[A_SD_LSB][1:0]};
	wire [9:0] sc_cb = {reg_q[A_SD_CB], reg_q[A_SD_LSB][3:2]};
	wire [9:0] sc_cr = {reg_q[A_SD_CR], reg_q[A_SD_LSB][5:4]};

	// Scale a colour difference by factor/512 around mid level
	// The value is re-centred to signed, scaled with rounding, clamped
	// to the signed byte range and moved back up to mid level.
	function automatic logic [7:0] sd_chroma(input logic [7:0] c, input logic [9:0] s);
		logic signed [19:0] p;
		logic signed [19:0] r;
		p = 20'($signed({{11{~c[7]}}, c[6:0]}) * $signed({10'h0, s}));
		r = (p + ROUND9) >>> 9;
		if (r < -20'sd128) begin
			return 8'h00;
		end else if (r > 20'sd127) begin
			return 8'hff;
		end
		return 8'(r[7:0] + MID8);
	endfunction

	// Round off eight fraction bits and clamp to the DAC word
	// Clamping keeps a strong colour from wrapping round to the wrong
	// end of the range.
	function automatic logic [9:0] sat10(input logic signed [21:0] v);
		logic signed [21:0] r;
		r = (v + ROUND8) >>> 8;
		if (r < 0) begin
			return 10'h000;
		end else if (r > 22'sd1023) begin
			return 10'h3ff;
		end
		return r[9:0];
	endfunction

	// Signed coefficient product
	// The coefficient is unsigned; the operand carries the sign.
	function automatic logic signed [21:0] cmul(input logic [9:0] k,
			input logic signed [9:0] v);
		return 22'($signed({12'h0, k}) * $signed({{12{v[9]}}, v}));
	endfunction

	// SD luma: gain value/512, then signed setup
	// Luma is unsigned, so it is scaled without re-centring. The setup
	// is seven bits in two's complement; bit seven of its register is
	// ignored. The sum is clamped to the byte before the matrix.
	wire [17:0] y_prod = 18'(pix_in.y * sc_y);
	wire [8:0] y_scl = 9'((y_prod + 18'(ROUND9)) >> 9);
	wire signed [10:0] setup = {{4{reg_q[A_SETUP][6]}}, reg_q[A_SETUP][6:0]};
	wire signed [10:0] y_sum = $signed({2'b00, y_scl}) + setup;
	wire [7:0] y_sd = (y_sum < 0) ? 8'h00 : (y_sum > 11'sd255) ? 8'hff : y_sum[7:0];

	// SD scaling runs ahead of every output path
	// Outside SD the scalers are bypassed, so progressive and HD pixels
	// reach the matrix unchanged.
	wire [7:0] y_m = is_sd ? y_sd : pix_in.y;
	wire [7:0] cb_m = is_sd ? sd_chroma(pix_in.cb, sc_cb) : pix_in.cb;
	wire [7:0] cr_m = is_sd ? sd_chroma(pix_in.cr, sc_cr) : pix_in.cr;

	// Matrix operands
	// Ten signed bits hold luma and both re-centred colour differences
	// with room to spare for the sign.
	wire signed [9:0] yv = $signed({2'b00, y_m});
	wire signed [9:0] pb = $signed({2'b00, cb_m}) - $signed({2'b00, MID8});
	wire signed [9:0] pr = $signed({2'b00, cr_m}) - $signed({2'b00, MID8});
	wire signed [21:0] ty = cmul(coef.gy, yv);

	// RGB sums; green terms subtract
	// Green takes both colour-difference terms away from the luma term;
	// blue and red each add one term.
	wire signed [21:0] g_sum = ty - cmul(coef.gu, pb) - cmul(coef.gv, pr);
	wire signed [21:0] b_sum = ty + cmul(coef.bu, pb);
	wire signed [21:0] r_sum = ty + cmul(coef.rv, pr);
	// Component scaling re-centred on mid code
	wire signed [21:0] u_sum = cmul(coef.bu, pb) + MID_OUT;
	wire signed [21:0] v_sum = cmul(coef.rv, pr) + MID_OUT;

	// Output selection: pattern, RGB pass, RGB matrix, components
	// The pattern wins over everything, then RGB input, then the matrix
	// in the chosen output space. Pattern and pass-through pad two zero
	// bits; the matrix paths round from the full-precision products.
	vcmc_pix_out_type nxt;
	always_comb begin
		nxt.valid = pix_in.valid;
		if (pat_on) begin
			// Pattern levels bypass the matrix entirely
			nxt.ch0 = {reg_q[A_PAT_Y], 2'b00};
			nxt.ch1 = {reg_q[A_PAT_CB], 2'b00};
			nxt.ch2 = {reg_q[A_PAT_CR], 2'b00};
		end else if (rgb_in) begin
			// RGB to RGB: green, blue, red as received
			nxt.ch0 = {pix_in.y, 2'b00};
			nxt.ch1 = {pix_in.cb, 2'b00};
			nxt.ch2 = {pix_in.cr, 2'b00};
		end else if (out_rgb) begin
			nxt.ch0 = sat10(g_sum);
			nxt.ch1 = sat10(b_sum);
			nxt.ch2 = sat10(r_sum);
		end else begin
			nxt.ch0 = sat10(ty);
			nxt.ch1 = sat10(u_sum);
			nxt.ch2 = sat10(v_sum);
		end
	end

	// Registered outputs; one cycle from input to pixel
	// Every output leaves from a flop, so downstream stages see settled
	// values one cycle after the pixel was taken.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pix_out <= '0;
			hue_step_out <= 8'h00;
			sinc_en_out <= 1'b0;
		end else begin
			pix_out <= nxt;
			// Signed step for the chroma subcarrier only
			hue_step_out <= reg_q[A_HUE] - MID8;
			// Sinc filter belongs to the progressive/HD path
			sinc_en_out <= reg_q[A_FILT][SINC_BIT] & ~is_sd;
		end
	end

endmodule

// ===== verification/testbench.sv
// Self-checking bench: serial register access and pixel checks
`timescale 1ns/1ps
module testbench;
	import vcmc_pkg::*;
	logic             clk_in = 1'b0;  // 50 MHz clock
	logic             rst_n_in;       // Reset, active low
	logic             scl = 1'b1;     // Master serial clock
	logic             sda_drv = 1'b1; // Master data, 1 releases
	logic             pattern_en_in;  // Pattern request
	logic [23:0]      want;           // Pixel for the formatter model
	vcmc_pix_in_type  pix;            // Pixel into the design
	vcmc_pix_out_type pix_out;        // Pixel out of the design
	logic [7:0]       hue_step_out;   // Hue phase step
	logic             sinc_en_out;    // Sinc filter enable
	logic             sda_oe_out;     // Design pulls data low
	logic             sda_out;        // Design drive value
	int               bad_count = 0;  // Mismatches
	int               checked = 0;    // Comparisons
	int               cycles = 0;     // Watchdog
	// Open-drain line with pull-up
	wire              sda_w = sda_drv & (sda_oe_out ? sda_out : 1'b1);
	// Matrix power-up contents, ascending offsets
	logic [7:0]       pu [7] = '{8'h03, 8'hf0, 8'h4e, 8'h0e, 8'h24, 8'h92, 8'h7c};

	always #10 clk_in = ~clk_in;

	vcmc_video_partner vcmc_video_partner_inst (.clk_in(clk_in), .want_in(want), .pix_out(pix));
	vcmc_top vcmc_top_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .scl_in(scl),
		.sda_in(sda_w), .sda_out(sda_out), .sda_oe_out(sda_oe_out), .pix_in(pix),
		.pattern_en_in(pattern_en_in), .pix_out(pix_out), .hue_step_out(hue_step_out),
		.sinc_en_out(sinc_en_out));

	task automatic summarize;
		$display("checked=%0d bad_count=%0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp_pix(input logic [29:0] exp);
		checked++;
		if ({pix_out.ch0, pix_out.ch1, pix_out.ch2} !== exp) begin
			bad_count++;
			$display("BAD %0t got=%h exp=%h", $time, {pix_out.ch0, pix_out.ch1, pix_out.ch2}, exp);
		end
	endtask
	// Data moves with the clock low, sampled late in the high phase
	task automatic bx(input logic b, output logic r);
		tick(2);
		sda_drv = b;
		tick(6);
		scl = 1'b1;
		tick(6);
		r = sda_w;
		scl = 1'b0;
	endtask
	task automatic start;
		tick(2);
		sda_drv = 1'b1;
		tick(6);
		scl = 1'b1;
		tick(6);
		sda_drv = 1'b0;
		tick(6);
		scl = 1'b0;
	endtask
	task automatic stop;
		tick(2);
		sda_drv = 1'b0;
		tick(6);
		scl = 1'b1;
		tick(6);
		sda_drv = 1'b1;
		tick(6);
	endtask
	task automatic bw(input logic [7:0] d, input logic nak);
		logic r;
		for (int i = 7; i >= 0; i--)
			bx(d[i], r);
		bx(1'b1, r);
		cmp_reg({7'h0, r}, {7'h0, nak});
	endtask
	task automatic reg_wr(input logic [6:0] a, input logic [7:0] d);
		start;
		bw({VCMC_DEV_ADDR, 1'b0}, 1'b0);
		bw({1'b0, a}, 1'b0);
		bw(d, 1'b0);
		stop;
	endtask
	// Set the subaddress, then a repeated start and one byte with NACK
	task automatic reg_rd(input logic [6:0] a, output logic [7:0] d);
		logic r;
		start;
		bw({VCMC_DEV_ADDR, 1'b0}, 1'b0);
		bw({1'b0, a}, 1'b0);
		start;
		bw({VCMC_DEV_ADDR, 1'b1}, 1'b0);
		for (int i = 7; i >= 0; i--)
			bx(1'b1, d[i]);
		bx(1'b1, r);
		stop;
	endtask
	function automatic logic [9:0] sat(input int s);
		int v;
		v = (s + 128) >>> 8;
		return (v < 0) ? 10'h000 : (v > 1023) ? 10'h3ff : v[9:0];
	endfunction
	// Expected matrix output; green subtracts both difference terms
	function automatic logic [29:0] mat(input int y, pb, pr,
			input vcmc_coef_type c, input logic rgb);
		int g;
		g = c.gy * y;
		if (rgb)
			return {sat(g - c.gu * pb - c.gv * pr), sat(g + c.bu * pb), sat(g + c.rv * pr)};
		return {sat(g), sat(c.bu * pb + 32'h20000), sat(c.rv * pr + 32'h20000)};
	endfunction
	task automatic show(input logic [7:0] y, cb, cr);
		want = {y, cb, cr};
		tick(4);
	endtask

	initial begin
		logic [7:0] d;
		vcmc_coef_type c;
		rst_n_in = 1'b0;
		pattern_en_in = 1'b0;
		want = {8'h64, 8'h80, 8'h80};
		tick(16);
		rst_n_in = 1'b1;
		for (int a = 3; a <= 9; a++) begin
			reg_rd(a[6:0], d);
			cmp_reg(d, pu[a - 3]);
		end
		cmp_reg(hue_step_out, 8'h00);
		show(8'h64, 8'h80, 8'h80);
		cmp_pix(mat(100, 0, 0, COEF_SD, 1'b0));
		// Gain 665/512 on all three scalers
		reg_wr(A_SD_LSB, 8'h15);
		reg_wr(A_SD_Y, 8'ha6);
		reg_wr(A_SD_CB, 8'ha6);
		reg_wr(A_SD_CR, 8'ha6);
		show(8'h64, 8'ha0, 8'h60);
		cmp_pix(mat(130, 42, -42, COEF_SD, 1'b0));
		// Top bit ignored, so this adds -14
		reg_wr(A_SETUP, 8'hf2);
		cmp_pix(mat(116, 42, -42, COEF_SD, 1'b0));
		reg_wr(A_SETUP, 8'h1e);
		cmp_pix(mat(160, 42, -42, COEF_SD, 1'b0));
		reg_wr(A_HUE, 8'h97);
		cmp_reg(hue_step_out, 8'h17);
		reg_wr(A_HUE, 8'h69);
		cmp_reg(hue_step_out, 8'he9);
		reg_wr(A_IN_MODE, 8'h20);
		cmp_reg({7'h0, sinc_en_out}, 8'h01);
		reg_wr(A_FILT, 8'h00);
		cmp_reg({7'h0, sinc_en_out}, 8'h00);
		reg_wr(A_FILT, 8'h08);
		show(8'h80, 8'h90, 8'h70);
		cmp_pix(mat(128, 16, -16, COEF_HD, 1'b0));
		reg_wr(A_OUT_CTRL, 8'h00);
		cmp_pix(mat(128, 16, -16, COEF_HD, 1'b1));
		// New coefficients stay idle until the override is set
		reg_wr(A_GY_HI, 8'h50);
		reg_wr(A_BR_LO, 8'hf3);
		cmp_pix(mat(128, 16, -16, COEF_HD, 1'b1));
		reg_wr(A_OUT_CTRL, 8'h08);
		reg_wr(A_PAT_Y, 8'h51);
		reg_wr(A_PAT_CR, 8'hf0);
		reg_wr(A_PAT_CB, 8'h5a);
		c = COEF_HD;
		c.gy = 10'h143;
		c.rv = 10'h1f3;
		cmp_pix(mat(128, 16, -16, c, 1'b1));
		pattern_en_in = 1'b1;
		tick(3);
		cmp_pix({10'h144, 10'h168, 10'h3c0});
		pattern_en_in = 1'b0;
		// SD ignores the override and RGB input
		reg_wr(A_IN_MODE, 8'h00);
		reg_wr(A_IN_SPACE, 8'h02);
		show(8'h64, 8'ha0, 8'h60);
		cmp_pix(mat(160, 42, -42, COEF_SD, 1'b1));
		cmp_reg({7'h0, sinc_en_out}, 8'h00);
		reg_rd(A_GY_HI, d);
		cmp_reg(d, 8'h50);
		// Progressive input: RGB passes, override acts, automatic set is SD's
		reg_wr(A_IN_MODE, 8'h10);
		show(8'h80, 8'h90, 8'h70);
		cmp_pix({10'h200, 10'h240, 10'h1c0});
		reg_wr(A_IN_SPACE, 8'h00);
		cmp_pix(mat(128, 16, -16, c, 1'b1));
		reg_wr(A_OUT_CTRL, 8'h20);
		cmp_pix(mat(128, 16, -16, COEF_SD, 1'b0));
		// Unmapped offset drops writes, foreign address gets no ACK
		reg_wr(7'h0a, 8'h5a);
		reg_rd(7'h0a, d);
		cmp_reg(d, 8'h00);
		start;
		bw({VCMC_DEV_ADDR ^ 7'h01, 1'b0}, 1'b1);
		stop;
		summarize;
	end

	// Hang guard, well above the expected run length
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 30000) begin
			bad_count++;
			summarize;
		end
	end
endmodule

// ===== verification/vcmc_top_properties.sv
// Port-level checks of the colour matrix control block
`timescale 1ns/1ps
module vcmc_top_properties
	import vcmc_pkg::*;
(
	input wire logic             clk_in,
	input wire logic             rst_n_in,
	input wire logic             scl_in,
	input wire logic             sda_in,
	input wire logic             sda_out,
	input wire logic             sda_oe_out,
	input wire vcmc_pix_in_type  pix_in,
	input wire logic             pattern_en_in,
	input wire vcmc_pix_out_type pix_out,
	input wire logic [7:0]       hue_step_out,
	input wire logic             sinc_en_out
);
	// Single clock domain
	default clocking main_cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	// Grey external pixel: both colour differences at mid-scale
	wire grey_w = pix_in.cb == 8'h80 && pix_in.cr == 8'h80 && !pattern_en_in;

	pix_latency_a: assert property (
		$past(rst_n_in) |-> pix_out.valid == $past(pix_in.valid))
		else $error("pixel valid not delayed by one cycle");
	chroma_mid_a: assert property (
		grey_w |=> pix_out.ch1 == pix_out.ch2)
		else $error("grey pixel gave unequal colour channels");
	grey_rgb_a: assert property (
		grey_w |=> pix_out.ch1 == 10'h200 || pix_out.ch0 == pix_out.ch1)
		else $error("grey pixel gave unequal primaries");
	hue_write_a: assert property (
		$changed(hue_step_out) |-> ##[0:4] sda_oe_out)
		else $error("hue step moved without a register write");
	sinc_write_a: assert property (
		$changed(sinc_en_out) |-> ##[0:4] sda_oe_out)
		else $error("sinc enable moved without a register write");
	// Settings change only through an acknowledged write
	out_steady_a: assert property (
		$past(rst_n_in, 2) && $changed({pix_out.ch0, pix_out.ch1, pix_out.ch2}) &&
		$past(pix_in[23:0]) == $past(pix_in[23:0], 2) &&
		$past(pattern_en_in) == $past(pattern_en_in, 2) |-> ##[0:4] sda_oe_out)
		else $error("pixel output moved with steady input and settings");
	// Sinc enable high means a non-SD mode, where the pattern is shown
	pattern_level_a: assert property (
		pattern_en_in && sinc_en_out |=> pix_out.ch0[1:0] == 2'h0 &&
		pix_out.ch1[1:0] == 2'h0 && pix_out.ch2[1:0] == 2'h0)
		else $error("pattern level not in upper channel bits");
	reset_hue_a: assert property (
		$past(rst_n_in) && !$past(rst_n_in, 2) |-> hue_step_out == 8'h00 && !sinc_en_out)
		else $error("hue step or sinc enable wrong after reset");
endmodule

bind vcmc_top vcmc_top_properties vcmc_top_properties_inst (
	.clk_in, .rst_n_in, .scl_in, .sda_in, .sda_out, .sda_oe_out, .pix_in,
	.pattern_en_in, .pix_out, .hue_step_out, .sinc_en_out);

// ===== verification/vcmc_video_partner.sv
// Input formatter model: presents one pixel per clock to the matrix
`timescale 1ns/1ps
module vcmc_video_partner
	import vcmc_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic [23:0] want_in,
	output vcmc_pix_in_type  pix_out
);
	// Start idle so the first sampled pixel is defined
	vcmc_pix_in_type pix_q = '0;
	assign pix_out = pix_q;
	// Launch after the edge; valid alternates so its delay is visible
	always @(posedge clk_in)
		pix_q <= #1 {~pix_q.valid, want_in};
endmodule
